// [shared/rsf_pkg.sv]
// package for the result status flag bank: bit positions, command kinds, event carrier
// assumes one controller clock domain and a synchronous active-high reset
package rsf_pkg;

  // ==========================================
  // status byte one bit positions
  localparam int SO_END_TRACK_BIT = 7;
  localparam int SO_CRC_FAULT_BIT = 5;
  localparam int SO_LATE_SVC_BIT = 4;
  localparam int SO_SECTOR_ABSENT_BIT = 2;
  localparam int SO_WRITE_LOCK_BIT = 1;
  localparam int SO_ID_SYNC_BIT = 0;

  // ==========================================
  // status byte two bit positions
  localparam int ST_CTRL_MARK_BIT = 6;
  localparam int ST_PAYLOAD_CRC_BIT = 5;
  localparam int ST_TRACK_MISMATCH_BIT = 4;
  localparam int ST_BAD_TRACK_BIT = 1;
  localparam int ST_PAYLOAD_SYNC_BIT = 0;

  // ==========================================
  // reset values and constants
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] LAST_SECTOR_NUM = 8'hff;
  localparam logic [7:0] BAD_TRACK_CYL = 8'hff;
  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  localparam logic [1:0] INDEX_LIMIT = 2'h2;

  // ==========================================
  // command kinds
  typedef enum logic [7:0] {
    RSF_CMD_NONE = 8'h01,
    RSF_CMD_READ_DATA = 8'h02,
    RSF_CMD_READ_DELETED = 8'h04,
    RSF_CMD_WRITE_DATA = 8'h08,
    RSF_CMD_WRITE_DELETED = 8'h10,
    RSF_CMD_FORMAT = 8'h20,
    RSF_CMD_READ_ID = 8'h40,
    RSF_CMD_READ_TRACK = 8'h80
  } rsf_cmd_e;

  // ==========================================
  // events reported by the sequencer, each a one-cycle pulse
  typedef struct packed {
    logic sector_passed;
    logic id_crc_bad;
    logic data_crc_bad;
    logic late_service;
    logic sector_missing;
    logic id_read_failed;
    logic sequence_lost;
    logic id_mark_seen;
    logic data_mark_missing;
    logic deleted_mark_seen;
    logic normal_mark_seen;
    logic id_valid;
  } rsf_event_s;

endpackage : rsf_pkg

// [rtl/rsf_status_flags.sv]
// result status flag bank: builds the second and third result bytes of a disk controller
// assumes the sequencer pulses events and reads the bytes only in its result phase
`timescale 1ns/1ns

module rsf_status_flags #(
  parameter int CYL_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // command sequencing
  input wire logic cmd_start,
  input wire rsf_pkg::rsf_cmd_e cmd_kind,
  input wire logic cmd_active,
  input wire logic result_phase,
  // drive and host signals
  input wire logic index_pulse_input,
  input wire logic write_protect_in,
  input wire logic transfer_count_end,
  // sector identity
  input wire logic [7:0] sector_num,
  input wire logic [CYL_W-1:0] id_cylinder,
  input wire logic [CYL_W-1:0] tracked_cylinder,
  // events
  input wire rsf_pkg::rsf_event_s evt,
  // result bytes
  output logic [7:0] result_status_one,
  output logic [7:0] result_status_two,
  output logic [1:0] termination_code
);
  import rsf_pkg::*;

  // ==========================================
  // flag state
  logic end_track_flag_reg;
  logic crc_fault_flag_reg;
  logic late_service_flag_reg;
  logic sector_absent_flag_reg;
  logic write_lock_hit_flag_reg;
  logic id_sync_lost_flag_reg;
  logic control_mark_flag_reg;
  logic payload_crc_flag_reg;
  logic track_mismatch_flag_reg;
  logic bad_track_flag_reg;
  logic payload_sync_lost_flag_reg;
  logic [1:0] index_count_reg;
  logic tc_seen_reg;
  logic wp_prev_reg;
  logic abnormal_reg;

  // ==========================================
  // decode helpers
  function automatic logic is_data_cmd(input rsf_cmd_e k);
    is_data_cmd = (k == RSF_CMD_READ_DATA) || (k == RSF_CMD_READ_DELETED) ||
                  (k == RSF_CMD_WRITE_DATA) || (k == RSF_CMD_WRITE_DELETED);
  endfunction

  function automatic logic is_write_cmd(input rsf_cmd_e k);
    is_write_cmd = (k == RSF_CMD_WRITE_DATA) || (k == RSF_CMD_WRITE_DELETED) ||
                   (k == RSF_CMD_FORMAT);
  endfunction

  function automatic logic is_read_sector_cmd(input rsf_cmd_e k);
    is_read_sector_cmd = (k == RSF_CMD_READ_DATA) || (k == RSF_CMD_READ_DELETED);
  endfunction

  logic live;
  logic cyl_diff;
  logic index_exhausted;
  logic wp_rise;
  assign live = cmd_active && !cmd_start;
  assign cyl_diff = evt.id_valid && (id_cylinder != tracked_cylinder);
  assign index_exhausted = (index_count_reg == INDEX_LIMIT - 2'h1) && index_pulse_input &&
                           !evt.id_mark_seen;
  assign wp_rise = write_protect_in && !wp_prev_reg;

  // ==========================================
  // qualifying notes
  // events count only in a live command, never in its start cycle
  // the start cycle clears every flag, so a stale cause cannot leak
  // into the next command's result bytes
  // the cylinder compare is meaningful only with a valid identifier
  // index counting stops at its limit to avoid wrapping back to zero
  // write protect is edge-taken so a drive already locked before
  // the command does not fire on every cycle

  // ==========================================
  // index pulse counting toward the missing identifier mark
  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start || evt.id_mark_seen) begin
      index_count_reg <= 2'h0;
    end else if (live && index_pulse_input && index_count_reg != INDEX_LIMIT) begin
      index_count_reg <= index_count_reg + 2'h1;
    end
  end

  // ==========================================
  // terminal count and write-protect edge tracking
  // terminal count is remembered for the rest of the command
  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      tc_seen_reg <= 1'b0;
    end else if (live && transfer_count_end) begin
      tc_seen_reg <= 1'b1;
    end
  end

  // previous write-protect level, for edge taking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_prev_reg <= 1'b0;
    end else begin
      wp_prev_reg <= write_protect_in;
    end
  end

  // ==========================================
  // second byte flags; each holds until the next command starts
  // last-sector overrun only counts when no terminal count arrived,
  // neither earlier in this command nor in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      end_track_flag_reg <= 1'b0;
    end else if (live && is_data_cmd(cmd_kind) && evt.sector_passed &&
                 sector_num == LAST_SECTOR_NUM && !tc_seen_reg && !transfer_count_end) begin
      end_track_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      crc_fault_flag_reg <= 1'b0;
    end else if (live && (evt.id_crc_bad || evt.data_crc_bad)) begin
      crc_fault_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      late_service_flag_reg <= 1'b0;
    end else if (live && evt.late_service) begin
      late_service_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      sector_absent_flag_reg <= 1'b0;
    // the read-sector, read-identifier and read-track kinds each have their own cause; write kinds have none, and a cause from another kind is ignored
    end else if (live && is_read_sector_cmd(cmd_kind) && evt.sector_missing) begin
      sector_absent_flag_reg <= 1'b1;
    end else if (live && cmd_kind == RSF_CMD_READ_ID && evt.id_read_failed) begin
      sector_absent_flag_reg <= 1'b1;
    end else if (live && cmd_kind == RSF_CMD_READ_TRACK && evt.sequence_lost) begin
      sector_absent_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      write_lock_hit_flag_reg <= 1'b0;
    end else if (live && is_write_cmd(cmd_kind) && wp_rise) begin
      write_lock_hit_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      id_sync_lost_flag_reg <= 1'b0;
    // either a lost identifier mark or a lost data mark lands in bit 0
    end else if (live && index_exhausted) begin
      id_sync_lost_flag_reg <= 1'b1;
    end else if (live && evt.data_mark_missing) begin
      id_sync_lost_flag_reg <= 1'b1;
    end
  end

  // ==========================================
  // third byte flags
  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      control_mark_flag_reg <= 1'b0;
    // mark-type mismatch depends on which read command is running
    end else if (live && cmd_kind == RSF_CMD_READ_DATA && evt.deleted_mark_seen) begin
      control_mark_flag_reg <= 1'b1;
    end else if (live && cmd_kind == RSF_CMD_READ_DELETED && evt.normal_mark_seen) begin
      control_mark_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      payload_crc_flag_reg <= 1'b0;
    end else if (live && evt.data_crc_bad) begin
      payload_crc_flag_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      track_mismatch_flag_reg <= 1'b0;
      bad_track_flag_reg <= 1'b0;
    end else if (live && cyl_diff) begin
      track_mismatch_flag_reg <= 1'b1;
      // a bad track is a mismatch whose cylinder reads all ones
      if (id_cylinder == CYL_W'(BAD_TRACK_CYL)) begin
        bad_track_flag_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      payload_sync_lost_flag_reg <= 1'b0;
    end else if (live && evt.data_mark_missing) begin
      payload_sync_lost_flag_reg <= 1'b1;
    end
  end

  // ==========================================
  // abnormal termination from sector missing or CRC failure
  // index exhaustion counts as abnormal too: the command ends without its target
  always_ff @(posedge clk) begin
    if (sys_rst || cmd_start) begin
      abnormal_reg <= 1'b0;
    end else if (live && (evt.sector_missing || evt.id_read_failed || evt.sequence_lost ||
                          evt.id_crc_bad || evt.data_crc_bad || index_exhausted)) begin
      abnormal_reg <= 1'b1;
    end
  end

  // ==========================================
  // result bytes, shown only while the result phase runs
  // bytes are rebuilt each cycle from the flags, unused bits forced low
  // the host sees zero from one edge after the result phase closes, so a read
  // outside the command sequence learns nothing
  always_ff @(posedge clk) begin
    if (sys_rst || !result_phase) begin
      result_status_one <= STATUS_RESET;
      result_status_two <= STATUS_RESET;
      termination_code <= TERM_NORMAL;
    end else begin
      result_status_one <= STATUS_RESET;
      result_status_one[SO_END_TRACK_BIT] <= end_track_flag_reg;
      result_status_one[SO_CRC_FAULT_BIT] <= crc_fault_flag_reg;
      result_status_one[SO_LATE_SVC_BIT] <= late_service_flag_reg;
      result_status_one[SO_SECTOR_ABSENT_BIT] <= sector_absent_flag_reg;
      result_status_one[SO_WRITE_LOCK_BIT] <= write_lock_hit_flag_reg;
      result_status_one[SO_ID_SYNC_BIT] <= id_sync_lost_flag_reg;
      result_status_two <= STATUS_RESET;
      result_status_two[ST_CTRL_MARK_BIT] <= control_mark_flag_reg;
      result_status_two[ST_PAYLOAD_CRC_BIT] <= payload_crc_flag_reg;
      result_status_two[ST_TRACK_MISMATCH_BIT] <= track_mismatch_flag_reg;
      result_status_two[ST_BAD_TRACK_BIT] <= bad_track_flag_reg;
      result_status_two[ST_PAYLOAD_SYNC_BIT] <= payload_sync_lost_flag_reg;
      termination_code <= abnormal_reg ? TERM_ABNORMAL : TERM_NORMAL;
    end
  end

endmodule // rsf_status_flags

// [tb/rsf_status_chk.sv]
// checker for the result status flag bank
// assumes it is bound to rsf_status_flags and sees only its ports
`timescale 1ns/1ns
module rsf_status_chk #(
  parameter int CYL_W = 8
) (
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // command and drive side
  input logic cmd_start,
  input rsf_pkg::rsf_cmd_e cmd_kind,
  input logic cmd_active,
  input logic result_phase,
  input logic [CYL_W-1:0] id_cylinder,
  input logic [CYL_W-1:0] tracked_cylinder,
  input rsf_pkg::rsf_event_s evt,
  // result bytes
  input logic [7:0] result_status_one,
  input logic [7:0] result_status_two,
  input logic [1:0] termination_code
);
  import rsf_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // event taken, result phase three cycles on, byte shows one edge later
  property p_sets(cause, shown);
    cmd_active && !cmd_start && cause ##1 (!cmd_start)[*3] ##0 result_phase |=> shown;
  endproperty
  a_zero_one_bits: assert property (result_status_one[6] == 1'b0 && result_status_one[3] == 1'b0)
    else $error("unused bits of byte one set");
  a_zero_two_bits: assert property (result_status_two[7] == 1'b0 && result_status_two[3:2] == 2'b00)
    else $error("unused bits of byte two set");
  a_term_values: assert property (termination_code[1] == 1'b0)
    else $error("termination code out of range");
  a_gate_idle: assert property (!result_phase |=> {result_status_one, result_status_two, termination_code} == 18'h0)
    else $error("result bytes visible outside result phase");
  a_start_clears: assert property (cmd_start |-> ##2 {result_status_one, result_status_two} == 16'h0000)
    else $error("flags survive a new command");
  a_crc_flag: assert property (p_sets(evt.id_crc_bad, result_status_one[5] && termination_code == 2'h1))
    else $error("identifier crc not reported");
  a_payload_crc: assert property (p_sets(evt.data_crc_bad, result_status_one[5] && result_status_two[5]))
    else $error("data crc not reported");
  a_late_flag: assert property (p_sets(evt.late_service, result_status_one[4]))
    else $error("late service not reported");
  a_mark_missing: assert property (p_sets(evt.data_mark_missing, result_status_one[0] && result_status_two[0]))
    else $error("missing data mark not reported");
  a_absent_read: assert property (p_sets(evt.sector_missing && cmd_kind == RSF_CMD_READ_DATA,
    result_status_one[2] && termination_code == 2'h1))
    else $error("missing sector not reported");
  a_bad_track: assert property (p_sets(evt.id_valid && id_cylinder != tracked_cylinder && id_cylinder == CYL_W'(8'hff),
    result_status_two[4] && result_status_two[1]))
    else $error("bad track not reported");
  c_crc: cover property (result_phase && result_status_one[5]);
  c_bad_track: cover property (result_phase && result_status_two[1]);
  c_abnormal: cover property (termination_code == 2'h1);
endmodule // rsf_status_chk

bind rsf_status_flags rsf_status_chk #(.CYL_W(CYL_W)) chk (.clk(clk), .sys_rst(sys_rst), .cmd_start(cmd_start),
  .cmd_kind(cmd_kind), .cmd_active(cmd_active), .result_phase(result_phase), .id_cylinder(id_cylinder),
  .tracked_cylinder(tracked_cylinder), .evt(evt), .result_status_one(result_status_one),
  .result_status_two(result_status_two), .termination_code(termination_code));

// [tb/rsf_host_model.sv]
// host model: opens the result phase on request and captures the result bytes
// assumes the flag bank answers one edge after it samples the result phase
`timescale 1ns/1ns
module rsf_host_model (
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // bench request
  input logic rd_req,
  // result bytes
  input logic [7:0] result_status_one,
  input logic [7:0] result_status_two,
  input logic [1:0] termination_code,
  // phase and captured bytes
  output logic result_phase,
  output logic rd_done,
  output logic [7:0] got_one,
  output logic [7:0] got_two,
  output logic [1:0] got_term
);
  logic [1:0] wait_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      result_phase <= 1'b0;
      wait_reg <= 2'h0;
      rd_done <= 1'b0;
    end else begin
      rd_done <= 1'b0;
      if (rd_req && !result_phase) begin
        result_phase <= 1'b1;
        wait_reg <= 2'h2;
      end else if (wait_reg == 2'h2) begin
        wait_reg <= 2'h1;
      end else if (wait_reg == 2'h1) begin
        wait_reg <= 2'h0;
        result_phase <= 1'b0;
        rd_done <= 1'b1;
        got_one <= result_status_one;
        got_two <= result_status_two;
        got_term <= termination_code;
      end
    end
  end
endmodule // rsf_host_model

// [tb/testbench.sv]
// self-checking bench for the result status flag bank
// assumes the host model reads the bytes and the checker is bound to the design
`timescale 1ns/1ns
module testbench;
  import rsf_pkg::*;
  logic clk, sys_rst, cmd_start, cmd_active, result_phase, idx, wp, tc, rd_req, rd_done;
  logic [7:0] sec, idc, trc, s_one, s_two, g_one, g_two;
  logic [1:0] term, g_term;
  rsf_cmd_e kind;
  rsf_event_s evt;
  int n_fail, n_compared;
  rsf_status_flags uut (.clk(clk), .sys_rst(sys_rst), .cmd_start(cmd_start), .cmd_kind(kind),
    .cmd_active(cmd_active), .result_phase(result_phase), .index_pulse_input(idx), .write_protect_in(wp),
    .transfer_count_end(tc), .sector_num(sec), .id_cylinder(idc), .tracked_cylinder(trc), .evt(evt),
    .result_status_one(s_one), .result_status_two(s_two), .termination_code(term));
  rsf_host_model host (.clk(clk), .sys_rst(sys_rst), .rd_req(rd_req), .result_status_one(s_one),
    .result_status_two(s_two), .termination_code(term), .result_phase(result_phase), .rd_done(rd_done),
    .got_one(g_one), .got_two(g_two), .got_term(g_term));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task end_sim;
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  // ==========================================
  // command, event and result phase helpers
  task start(input rsf_cmd_e k);
    @(posedge clk);
    cmd_start <= 1'b1;
    kind <= k;
    cmd_active <= 1'b1;
    @(posedge clk);
    cmd_start <= 1'b0;
  endtask
  task fire(input rsf_event_s e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask
  task rd(input logic [7:0] one, input logic [7:0] two, input logic [1:0] t);
    @(posedge clk);
    cmd_active <= 1'b0;
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (rd_done === 1'b1) break;
    end
    if (rd_done !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    chk(g_one, one);
    chk(g_two, two);
    chk({6'h00, g_term}, {6'h00, t});
  endtask
  // ==========================================
  // scenarios
  task t_crc_late;
    start(RSF_CMD_READ_DATA);
    fire('{id_crc_bad: 1'b1, default: 1'b0});
    rd(8'h20, 8'h00, 2'h1);
    start(RSF_CMD_READ_DATA);
    fire('{data_crc_bad: 1'b1, default: 1'b0});
    rd(8'h20, 8'h20, 2'h1);
    start(RSF_CMD_WRITE_DATA);
    fire('{late_service: 1'b1, default: 1'b0});
    rd(8'h10, 8'h00, 2'h0);
    start(RSF_CMD_READ_DATA);
    rd(8'h00, 8'h00, 2'h0);
    $display("crc and late service test done");
  endtask
  task t_end_track;
    start(RSF_CMD_READ_DATA);
    sec <= 8'hff;
    fire('{sector_passed: 1'b1, default: 1'b0});
    rd(8'h80, 8'h00, 2'h0);
    start(RSF_CMD_WRITE_DATA);
    tc <= 1'b1;
    fire('{sector_passed: 1'b1, default: 1'b0});
    tc <= 1'b0;
    rd(8'h00, 8'h00, 2'h0);
    $display("end of track test done");
  endtask
  task automatic t_absent;
    rsf_cmd_e ks[4] = '{RSF_CMD_READ_DATA, RSF_CMD_READ_DELETED, RSF_CMD_READ_ID, RSF_CMD_READ_TRACK};
    rsf_event_s es[4] = '{'{sector_missing: 1'b1, default: 1'b0}, '{sector_missing: 1'b1, default: 1'b0},
      '{id_read_failed: 1'b1, default: 1'b0}, '{sequence_lost: 1'b1, default: 1'b0}};
    for (int i = 0; i < 4; i++) begin
      start(ks[i]);
      fire(es[i]);
      rd(8'h04, 8'h00, 2'h1);
    end
    $display("sector absent test done");
  endtask
  task automatic t_write_lock;
    rsf_cmd_e ks[4] = '{RSF_CMD_WRITE_DATA, RSF_CMD_WRITE_DELETED, RSF_CMD_FORMAT, RSF_CMD_READ_DATA};
    for (int i = 0; i < 4; i++) begin
      start(ks[i]);
      @(posedge clk);
      wp <= 1'b1;
      @(posedge clk);
      wp <= 1'b0;
      rd((i < 3) ? 8'h02 : 8'h00, 8'h00, 2'h0);
    end
    $display("write lock test done");
  endtask
  task t_marks;
    start(RSF_CMD_READ_DATA);
    fire('{deleted_mark_seen: 1'b1, default: 1'b0});
    rd(8'h00, 8'h40, 2'h0);
    start(RSF_CMD_READ_DELETED);
    fire('{normal_mark_seen: 1'b1, default: 1'b0});
    rd(8'h00, 8'h40, 2'h0);
    start(RSF_CMD_READ_DATA);
    fire('{data_mark_missing: 1'b1, default: 1'b0});
    rd(8'h01, 8'h01, 2'h0);
    start(RSF_CMD_READ_DATA);
    repeat (2) begin
      @(posedge clk);
      idx <= 1'b1;
      @(posedge clk);
      idx <= 1'b0;
    end
    rd(8'h01, 8'h00, 2'h1);
    start(RSF_CMD_READ_DATA);
    @(posedge clk);
    idx <= 1'b1;
    @(posedge clk);
    idx <= 1'b0;
    fire('{id_mark_seen: 1'b1, default: 1'b0});
    @(posedge clk);
    idx <= 1'b1;
    @(posedge clk);
    idx <= 1'b0;
    rd(8'h00, 8'h00, 2'h0);
    $display("address mark test done");
  endtask
  task t_cylinder;
    start(RSF_CMD_READ_DATA);
    trc <= 8'h03;
    idc <= 8'h05;
    fire('{id_valid: 1'b1, default: 1'b0});
    rd(8'h00, 8'h10, 2'h0);
    start(RSF_CMD_READ_DATA);
    idc <= 8'hff;
    fire('{id_valid: 1'b1, default: 1'b0});
    rd(8'h00, 8'h12, 2'h0);
    $display("cylinder test done");
  endtask
  initial begin
    n_fail = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    {cmd_start, cmd_active, idx, wp, tc, rd_req} = '0;
    {sec, idc, trc} = '0;
    kind = RSF_CMD_NONE;
    evt = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_crc_late();
    t_end_track();
    t_absent();
    t_write_lock();
    t_marks();
    t_cylinder();
    end_sim();
  end
endmodule // testbench
